// [rtl/cmd_device.sv]
// direct-mode command handler, device end
`timescale 1ns/100ps
module cmd_device
    import cmd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    cmd_link_if.device       link,
    input  wire logic        target_reached,
    input  wire logic        prog_wait_flag,
    input  wire logic [31:0] prog_accu,
    input  wire logic [31:0] prog_index,
    output logic             prog_run,
    output logic             prog_step,
    output logic             prog_halt,
    output logic             prog_clear,
    output logic             prog_load_pc,
    output logic [31:0]      prog_pc_value,
    output logic             factory_restore,
    output logic             cpu_restart,
    output logic [7:0]       exec_opcode,
    output logic [7:0]       exec_type,
    output logic [31:0]      exec_value,
    output logic             exec_valid,
    output logic             download_mode
);
    import cmd_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum {S_RX, S_EXEC, S_TX} phase_e;

    typedef struct packed {
        phase_e           phase;
        logic [3:0]       idx;
        logic [71:0]      rx;
        logic [71:0]      tx;
        logic             tx_later;
        logic             pend_later;
        logic             arm_once;
        logic             arm_all;
        logic             move_seen;
        logic             dl;
        logic [MEM_AW-1:0] mem_ptr;
        logic [MEM_AW-1:0] pc;
        logic [7:0]       sum;
        logic             run;
        logic             step;
        logic             halt;
        logic             clear;
        logic             load_pc;
        logic [31:0]      pc_value;
        logic             factory;
        logic             restart;
        logic             exec;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [31:0] mem [MEM_WORDS];
    logic        mem_we;
    logic [31:0] mem_rd;

    logic [7:0]  f_op;
    logic [7:0]  f_type;
    logic [31:0] f_val;
    logic [7:0]  f_sum;
    assign f_op   = st_reg.rx[63:56];
    assign f_type = st_reg.rx[55:48];
    assign f_val  = st_reg.rx[39:8];
    assign f_sum  = st_reg.rx[7:0];

    function automatic logic [71:0] build(input logic [7:0] status,
                                          input logic [7:0] cmd,
                                          input logic [31:0] val);
        logic [7:0] s;
        s = HOST_ADDR + MODULE_ADDR + status + cmd + val[31:24]
            + val[23:16] + val[15:8] + val[7:0];
        build = {HOST_ADDR, MODULE_ADDR, status, cmd, val, s};
    endfunction

    // ****************************************************************
    // program memory
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[st_reg.mem_ptr] <= st_reg.rx[63:32];
        end
    end
    assign mem_rd = mem[f_val[MEM_AW-1:0]];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        mem_we = 1'b0;
        st_next.run = 1'b0;
        st_next.step = 1'b0;
        st_next.halt = 1'b0;
        st_next.clear = 1'b0;
        st_next.load_pc = 1'b0;
        st_next.factory = 1'b0;
        st_next.restart = 1'b0;
        st_next.exec = 1'b0;
        // event sets win over the clear when the later reply is sent
        if (target_reached && st_reg.move_seen) begin
            st_next.pend_later = 1'b1;
            st_next.move_seen = 1'b0;
        end
        unique case (st_reg.phase)
            S_RX: begin
                if (st_reg.pend_later && st_reg.idx == 4'h0) begin
                    st_next.tx = build(ST_POS_REACHED, OP_POS_REQ,
                                       {24'h0, MOTOR_MASK});
                    st_next.pend_later = target_reached
                                         && st_reg.move_seen;
                    st_next.phase = S_TX;
                    st_next.idx = 4'h0;
                    st_next.tx_later = 1'b1;
                end else if (link.cmd_valid) begin
                    st_next.rx = {st_reg.rx[63:0], link.cmd_data};
                    st_next.sum = (st_reg.idx == 4'h8) ? st_reg.sum
                                  : st_reg.sum + link.cmd_data;
                    if (st_reg.idx == 4'(FRAME_BYTES - 1)) begin
                        st_next.phase = S_EXEC;
                        st_next.idx = 4'h0;
                    end else begin
                        st_next.idx = st_reg.idx + 4'h1;
                    end
                end
            end
            S_EXEC: begin
                st_next.phase = S_TX;
                st_next.sum = 8'h00;
                st_next.tx_later = 1'b0;
                st_next.tx = build(ST_OK, f_op, 32'h0);
                if (f_sum != st_reg.sum) begin
                    st_next.tx = build(ST_BAD_CHECKSUM, f_op, 32'h0);
                end else if (f_op == OP_POS_REQ) begin
                    // handled directly, never stored in download mode
                    st_next.arm_once = (f_type == 8'h00);
                    st_next.arm_all = (f_type == 8'h01);
                    st_next.tx = build(ST_OK, OP_POS_REQ,
                                       {24'h0, f_val[7:0]});
                end else if (f_op[7] == 1'b1) begin
                    // control commands act even in download mode
                    unique case (f_op)
                        OP_STOP_APP: st_next.halt = 1'b1;
                        OP_RUN_APP: begin
                            st_next.run = 1'b1;
                            st_next.load_pc = (f_type == 8'h01);
                            st_next.pc_value = f_val;
                            if (f_type == 8'h01) begin
                                st_next.pc = f_val[MEM_AW-1:0];
                            end
                        end
                        OP_STEP_APP: st_next.step = 1'b1;
                        OP_RESET_APP: begin
                            st_next.clear = 1'b1;
                            st_next.halt = 1'b1;
                            st_next.pc = '0;
                        end
                        OP_DL_ENTER: begin
                            st_next.dl = 1'b1;
                            st_next.mem_ptr = f_val[MEM_AW-1:0];
                        end
                        OP_DL_EXIT: st_next.dl = 1'b0;
                        OP_READ_MEM:
                            st_next.tx = build(ST_OK, f_op, mem_rd);
                        OP_APP_STATUS: begin
                            unique case (f_type)
                                8'h00: st_next.tx = build(ST_OK, f_op,
                                    {7'h0, st_reg.dl, 7'h0, prog_wait_flag,
                                     8'h0, st_reg.mem_ptr});
                                8'h01: st_next.tx = build(ST_OK, f_op,
                                    {7'h0, st_reg.dl, 7'h0, prog_wait_flag,
                                     8'h0, st_reg.pc});
                                8'h02: st_next.tx = build(ST_OK, f_op,
                                                          prog_accu);
                                8'h03: st_next.tx = build(ST_OK, f_op,
                                                          prog_index);
                                default: st_next.tx = build(ST_BAD_COMMAND,
                                                            f_op, 32'h0);
                            endcase
                        end
                        OP_FW_VERSION:
                            st_next.tx = build(ST_OK, f_op,
                                               FW_VERSION_WORD);
                        OP_FACTORY: begin
                            if (f_val == MAGIC_VALUE) begin
                                st_next.factory = 1'b1;
                                st_next.phase = S_RX;
                            end
                        end
                        OP_SOFT_RESET: begin
                            if (f_val == MAGIC_VALUE) begin
                                st_next.restart = 1'b1;
                            end
                        end
                        default: st_next.tx = build(ST_BAD_COMMAND, f_op,
                                                    32'h0);
                    endcase
                end else if (st_reg.dl) begin
                    mem_we = 1'b1;
                    st_next.mem_ptr = st_reg.mem_ptr + 1'b1;
                    st_next.tx = build(ST_STORED, f_op, 32'h0);
                end else begin
                    st_next.exec = 1'b1;
                    if (f_op == OP_MOVE_POS
                        && (st_reg.arm_once || st_reg.arm_all)) begin
                        st_next.move_seen = 1'b1;
                        st_next.arm_once = 1'b0;
                    end
                    // user opcodes answer with the default ST_OK reply
                end
            end
            S_TX: begin
                if (link.rsp_ready) begin
                    st_next.tx = {st_reg.tx[63:0], 8'h00};
                    if (st_reg.idx == 4'(FRAME_BYTES - 1)) begin
                        st_next.phase = S_RX;
                        st_next.idx = 4'h0;
                    end else begin
                        st_next.idx = st_reg.idx + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst || st_reg.restart) begin
            st_reg <= '0;
            st_reg.phase <= S_RX;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign link.cmd_ready  = (st_reg.phase == S_RX)
                             && !(st_reg.pend_later && st_reg.idx == 4'h0);
    assign link.rsp_valid  = (st_reg.phase == S_TX);
    assign link.rsp_data   = st_reg.tx[71:64];
    assign prog_run        = st_reg.run;
    assign prog_step       = st_reg.step;
    assign prog_halt       = st_reg.halt;
    assign prog_clear      = st_reg.clear;
    assign prog_load_pc    = st_reg.load_pc;
    assign prog_pc_value   = st_reg.pc_value;
    assign factory_restore = st_reg.factory;
    assign cpu_restart     = st_reg.restart;
    assign exec_opcode     = st_reg.rx[63:56];
    assign exec_type       = st_reg.rx[55:48];
    assign exec_value      = st_reg.rx[39:8];
    assign exec_valid      = st_reg.exec;
    assign download_mode   = st_reg.dl;
endmodule

// [rtl/cmd_host.sv]
// host end: sends one command frame, collects reply frames
`timescale 1ns/100ps
module cmd_host
    import cmd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    cmd_link_if.host         link,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_opcode,
    input  wire logic [7:0]  req_type,
    input  wire logic [31:0] req_value,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_status,
    output logic [7:0]       rsp_command,
    output logic [31:0]      rsp_value,
    output logic             rsp_sum_ok
);
    import cmd_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic        busy;
        logic [3:0]  tidx;
        logic [71:0] tx;
        logic [3:0]  ridx;
        logic [71:0] rx;
        logic [7:0]  rsum;
        logic        done;
        logic [7:0]  status;
        logic [7:0]  command;
        logic [31:0] value;
        logic        ok;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic [7:0]  bank;
    logic [31:0] val;
    logic [7:0]  s;

    always_comb begin
        // motor/bank zero; position request mask forced to 1
        bank = 8'h00;
        val = (req_opcode == OP_POS_REQ) ? {24'h0, MOTOR_MASK} : req_value;
        s = MODULE_ADDR + req_opcode + req_type + bank + val[31:24]
            + val[23:16] + val[15:8] + val[7:0];
        st_next = st_reg;
        st_next.done = 1'b0;
        if (!st_reg.busy && req_valid) begin
            st_next.busy = 1'b1;
            st_next.tidx = 4'h0;
            st_next.tx = {MODULE_ADDR, req_opcode, req_type, bank, val, s};
        end else if (st_reg.busy && link.cmd_ready) begin
            st_next.tx = {st_reg.tx[63:0], 8'h00};
            st_next.tidx = st_reg.tidx + 4'h1;
            if (st_reg.tidx == 4'(FRAME_BYTES - 1)) begin
                st_next.busy = 1'b0;
            end
        end
        // replies are collected independently; none may ever come
        if (link.rsp_valid) begin
            st_next.rx = {st_reg.rx[63:0], link.rsp_data};
            st_next.rsum = st_reg.rsum + link.rsp_data;
            st_next.ridx = st_reg.ridx + 4'h1;
            if (st_reg.ridx == 4'(FRAME_BYTES - 1)) begin
                st_next.ridx = 4'h0;
                st_next.rsum = 8'h00;
                st_next.done = 1'b1;
                st_next.status = st_reg.rx[47:40];
                st_next.command = st_reg.rx[39:32];
                st_next.value = {st_reg.rx[31:0]};
                st_next.ok = (st_reg.rsum == link.rsp_data);
                st_next.value = {st_reg.rx[31:0]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.cmd_valid = st_reg.busy;
    assign link.cmd_data  = st_reg.tx[71:64];
    assign link.rsp_ready = 1'b1;
    assign req_ready      = !st_reg.busy;
    assign rsp_valid      = st_reg.done;
    assign rsp_status     = st_reg.status;
    assign rsp_command    = st_reg.command;
    assign rsp_value      = st_reg.value;
    assign rsp_sum_ok     = st_reg.ok;
endmodule

// [rtl/cmd_link_if.sv]
// byte stream link between host end and device end
`timescale 1ns/100ps
interface cmd_link_if;
    logic [7:0] cmd_data;
    logic       cmd_valid;
    logic       cmd_ready;
    logic [7:0] rsp_data;
    logic       rsp_valid;
    logic       rsp_ready;
    modport device (input cmd_data, input cmd_valid, output cmd_ready,
                    output rsp_data, output rsp_valid, input rsp_ready);
    modport host (output cmd_data, output cmd_valid, input cmd_ready,
                  input rsp_data, input rsp_valid, output rsp_ready);
endinterface

// [rtl/cmd_pkg.sv]
// constants and types shared by the command handler and the host end
package cmd_pkg;
    localparam int          FRAME_BYTES      = 9;
    localparam logic [7:0]  OP_USER_FIRST    = 8'h40;
    localparam logic [7:0]  OP_USER_LAST     = 8'h47;
    localparam logic [7:0]  OP_MOVE_POS      = 8'h04;
    localparam logic [7:0]  OP_POS_REQ       = 8'h8A;
    localparam logic [7:0]  OP_STOP_APP      = 8'h80;
    localparam logic [7:0]  OP_RUN_APP       = 8'h81;
    localparam logic [7:0]  OP_STEP_APP      = 8'h82;
    localparam logic [7:0]  OP_RESET_APP     = 8'h83;
    localparam logic [7:0]  OP_DL_ENTER      = 8'h84;
    localparam logic [7:0]  OP_DL_EXIT       = 8'h85;
    localparam logic [7:0]  OP_READ_MEM      = 8'h86;
    localparam logic [7:0]  OP_APP_STATUS    = 8'h87;
    localparam logic [7:0]  OP_FW_VERSION    = 8'h88;
    localparam logic [7:0]  OP_FACTORY       = 8'h89;
    localparam logic [7:0]  OP_SOFT_RESET    = 8'hFF;
    localparam logic [7:0]  ST_OK            = 8'h64;
    localparam logic [7:0]  ST_POS_REACHED   = 8'h80;
    localparam logic [7:0]  ST_BAD_CHECKSUM  = 8'h01;
    localparam logic [7:0]  ST_BAD_COMMAND   = 8'h02;
    localparam logic [7:0]  ST_STORED        = 8'h65;
    localparam logic [31:0] MAGIC_VALUE      = 32'h0000_04D2;
    localparam logic [7:0]  MOTOR_MASK       = 8'h01;
    localparam logic [7:0]  MODULE_ADDR      = 8'h01;
    localparam logic [7:0]  HOST_ADDR        = 8'h02;
    // arbitrary version word
    localparam logic [31:0] FW_VERSION_WORD  = 32'h0000_0101;
    localparam int          MEM_WORDS        = 256;
    localparam int          MEM_AW           = 8;
    typedef logic [7:0] byte_t;
    typedef byte_t frame_t [FRAME_BYTES];
endpackage

// [testbench/cmd_link_asserts.sv]
// concurrent checks on the command link between host end and device end
`timescale 1ns/100ps
module cmd_link_asserts
    import cmd_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_valid,
    input wire logic       rsp_ready
);
    logic [3:0] ccnt_reg;
    logic [3:0] rcnt_reg;
    logic [7:0] csum_reg;
    logic [7:0] rsum_reg;
    logic [7:0] rcmd_reg;
    logic       cmd_hs;
    logic       rsp_hs;
    assign cmd_hs = cmd_valid && cmd_ready;
    assign rsp_hs = rsp_valid && rsp_ready;

    // ************************************************************
    // byte position and running sum of each frame
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ccnt_reg <= 4'h0;
            rcnt_reg <= 4'h0;
            csum_reg <= 8'h00;
            rsum_reg <= 8'h00;
            rcmd_reg <= 8'h00;
        end else begin
            if (cmd_hs) begin
                ccnt_reg <= (ccnt_reg == 4'h8) ? 4'h0 : ccnt_reg + 4'h1;
                csum_reg <= (ccnt_reg == 4'h8) ? 8'h00 : csum_reg + cmd_data;
            end
            if (rsp_hs) begin
                rcnt_reg <= (rcnt_reg == 4'h8) ? 4'h0 : rcnt_reg + 4'h1;
                rsum_reg <= (rcnt_reg == 4'h8) ? 8'h00 : rsum_reg + rsp_data;
                if (rcnt_reg == 4'h3) begin
                    rcmd_reg <= rsp_data;
                end
            end
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    reset_idle_a: assert property (
        $past(srst) |-> cmd_ready && !rsp_valid)
        else $error("link not idle after reset");
    cmd_hold_a: assert property (
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("command byte dropped before accept");
    rsp_hold_a: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("reply byte dropped before accept");
    exec_gap_a: assert property (
        cmd_hs && ccnt_reg == 4'h8 |=> !cmd_ready && !rsp_valid)
        else $error("no execute cycle after ninth byte");
    rsp_host_a: assert property (
        rsp_hs && rcnt_reg == 4'h0 |-> rsp_data == HOST_ADDR)
        else $error("reply first byte wrong");
    rsp_module_a: assert property (
        rsp_hs && rcnt_reg == 4'h1 |-> rsp_data == MODULE_ADDR)
        else $error("reply second byte wrong");
    cmd_bank_a: assert property (
        cmd_hs && ccnt_reg == 4'h3 |-> cmd_data == 8'h00)
        else $error("motor bank byte not zero");
    cmd_sum_a: assert property (
        cmd_hs && ccnt_reg == 4'h8 |-> cmd_data == csum_reg)
        else $error("command checksum wrong");
    rsp_sum_a: assert property (
        rsp_hs && rcnt_reg == 4'h8 |-> rsp_data == rsum_reg)
        else $error("reply checksum wrong");
    pos_high_a: assert property (
        rsp_hs && rcmd_reg == OP_POS_REQ && rcnt_reg inside {4'h4, 4'h5, 4'h6}
        |-> rsp_data == 8'h00)
        else $error("position reply high value byte not zero");
    pos_mask_a: assert property (
        rsp_hs && rcmd_reg == OP_POS_REQ && rcnt_reg == 4'h7
        |-> rsp_data == MOTOR_MASK)
        else $error("position reply mask wrong");
    serial_frames_a: assert property (
        rsp_valid |-> !cmd_ready)
        else $error("command taken during reply");
endmodule

// [testbench/tb_top.sv]
// testbench top: host end and device end joined over the link
`timescale 1ns/100ps
module tb_top;
    import cmd_pkg::*;
    logic        clk_sys;
    logic        srst;
    logic        req_valid;
    logic [7:0]  req_opcode;
    logic [7:0]  req_type;
    logic [31:0] req_value;
    logic        req_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_status;
    logic [7:0]  rsp_command;
    logic [31:0] rsp_value;
    logic        rsp_sum_ok;
    logic        target_reached;
    logic        prog_wait_flag;
    logic [31:0] prog_accu;
    logic [31:0] prog_index;
    logic [7:0]  pls;
    logic [31:0] pc_value;
    logic [7:0]  exec_opcode;
    logic        download_mode;
    int          hits [8];
    int          error_cnt;
    int          total_checks;

    cmd_link_if link ();
    cmd_host cmd_host_inst (.clk_sys(clk_sys), .srst(srst), .link(link),
        .req_valid(req_valid), .req_opcode(req_opcode),
        .req_type(req_type), .req_value(req_value), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_command(rsp_command), .rsp_value(rsp_value),
        .rsp_sum_ok(rsp_sum_ok));
    // pulse bits: run step halt clear load_pc factory restart exec
    cmd_device cmd_device_inst (.clk_sys(clk_sys), .srst(srst), .link(link),
        .target_reached(target_reached), .prog_wait_flag(prog_wait_flag),
        .prog_accu(prog_accu), .prog_index(prog_index),
        .prog_run(pls[0]), .prog_step(pls[1]), .prog_halt(pls[2]),
        .prog_clear(pls[3]), .prog_load_pc(pls[4]),
        .prog_pc_value(pc_value), .factory_restore(pls[5]),
        .cpu_restart(pls[6]), .exec_opcode(exec_opcode), .exec_type(),
        .exec_value(), .exec_valid(pls[7]),
        .download_mode(download_mode));
    cmd_link_asserts cmd_link_asserts_inst (.clk_sys(clk_sys), .srst(srst),
        .cmd_data(link.cmd_data), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .rsp_data(link.rsp_data),
        .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (pls[i] === 1'b1) begin
                hits[i]++;
            end
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] op, input logic [7:0] ty,
                        input logic [31:0] val);
        int n;
        @(posedge clk_sys);
        hits = '{default: 0};
        req_valid  <= 1'b1;
        req_opcode <= op;
        req_type   <= ty;
        req_value  <= val;
        for (n = 0; n < 60; n++) begin
            @(negedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        if (n == 60) begin
            error_cnt++;
            final_report();
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask

    task automatic expect_rsp(input logic [7:0] st, input logic [7:0] cm,
                              input logic [31:0] val, input logic [31:0] msk);
        int n;
        for (n = 0; n < 80; n++) begin
            @(negedge clk_sys);
            if (rsp_valid === 1'b1) break;
        end
        if (n == 80) begin
            error_cnt++;
            final_report();
        end
        chk("status", {24'h0, rsp_status}, {24'h0, st});
        chk("command", {24'h0, rsp_command}, {24'h0, cm});
        chk("value", rsp_value & msk, val & msk);
        chk("sum", {31'h0, rsp_sum_ok}, 32'h1);
        @(posedge clk_sys);
    endtask

    task automatic no_rsp(input int cyc);
        repeat (cyc) begin
            @(negedge clk_sys);
            chk("quiet", {31'h0, rsp_valid}, 32'h0);
        end
        @(posedge clk_sys);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_user();
        for (int i = 0; i < 8; i++) begin
            send(OP_USER_FIRST + 8'(i), 8'h00, 32'h0);
            expect_rsp(ST_OK, OP_USER_FIRST + 8'(i), 32'h0, '1);
            chk("exec", hits[7], 1);
            chk("opcode", {24'h0, exec_opcode}, 32'h40 + i);
        end
    endtask

    task automatic move(input logic armed);
        send(OP_MOVE_POS, 8'h00, 32'h0000_0100);
        expect_rsp(ST_OK, OP_MOVE_POS, 32'h0, '1);
        no_rsp(5);
        target_reached <= 1'b1;
        if (armed) begin
            expect_rsp(ST_POS_REACHED, OP_POS_REQ, 32'h1, '1);
        end else begin
            no_rsp(20);
        end
        target_reached <= 1'b0;
    endtask

    task automatic t_pos();
        send(OP_POS_REQ, 8'h00, 32'h1);
        expect_rsp(ST_OK, OP_POS_REQ, 32'h1, '1);
        move(1'b1);
        move(1'b0);
        send(OP_POS_REQ, 8'h01, 32'h1);
        expect_rsp(ST_OK, OP_POS_REQ, 32'h1, '1);
        move(1'b1);
        move(1'b1);
    endtask

    task automatic t_ctrl();
        logic [7:0] ops [3] = '{OP_STOP_APP, OP_STEP_APP, OP_RESET_APP};
        int         idx [3] = '{2, 1, 3};
        for (int i = 0; i < 3; i++) begin
            send(ops[i], 8'h00, 32'h0);
            expect_rsp(ST_OK, ops[i], 32'h0, '1);
            chk("pulse", hits[idx[i]], 1);
        end
        send(OP_RUN_APP, 8'h00, 32'h0);
        expect_rsp(ST_OK, OP_RUN_APP, 32'h0, '1);
        chk("run", hits[0], 1);
        chk("load", hits[4], 0);
        send(OP_RUN_APP, 8'h01, 32'h0000_0010);
        expect_rsp(ST_OK, OP_RUN_APP, 32'h0, '1);
        chk("load", hits[4], 1);
        chk("pc", pc_value, 32'h0000_0010);
    endtask

    task automatic t_prog();
        send(OP_DL_ENTER, 8'h00, 32'h0000_0005);
        expect_rsp(ST_OK, OP_DL_ENTER, 32'h0, '1);
        chk("mode", {31'h0, download_mode}, 32'h1);
        send(OP_USER_FIRST, 8'h03, 32'h1200_0000);
        expect_rsp(ST_STORED, OP_USER_FIRST, 32'h0, '1);
        chk("exec", hits[7], 0);
        prog_wait_flag <= 1'b1;
        send(OP_APP_STATUS, 8'h01, 32'h0);
        expect_rsp(ST_OK, OP_APP_STATUS, 32'h0101_0010, '1);
        send(OP_DL_EXIT, 8'h00, 32'h0);
        expect_rsp(ST_OK, OP_DL_EXIT, 32'h0, '1);
        chk("mode", {31'h0, download_mode}, 32'h0);
        send(OP_READ_MEM, 8'h00, 32'h0000_0005);
        expect_rsp(ST_OK, OP_READ_MEM, 32'h4003_0012, '1);
        send(OP_APP_STATUS, 8'h02, 32'h0);
        expect_rsp(ST_OK, OP_APP_STATUS, prog_accu, '1);
        send(OP_APP_STATUS, 8'h03, 32'h0);
        expect_rsp(ST_OK, OP_APP_STATUS, prog_index, '1);
        send(OP_APP_STATUS, 8'h04, 32'h0);
        expect_rsp(ST_BAD_COMMAND, OP_APP_STATUS, 32'h0, '1);
        send(OP_FW_VERSION, 8'h01, 32'h0);
        expect_rsp(ST_OK, OP_FW_VERSION, FW_VERSION_WORD, '1);
    endtask

    task automatic t_restart();
        send(OP_FACTORY, 8'h00, MAGIC_VALUE);
        no_rsp(40);
        chk("factory", hits[5], 1);
        send(OP_SOFT_RESET, 8'h00, MAGIC_VALUE);
        repeat (40) @(posedge clk_sys);
        chk("restart", hits[6], 1);
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        send(OP_USER_LAST, 8'h00, 32'h0);
        expect_rsp(ST_OK, OP_USER_LAST, 32'h0, '1);
    endtask

    initial begin
        srst           = 1'b1;
        req_valid      = 1'b0;
        req_opcode     = 8'h00;
        req_type       = 8'h00;
        req_value      = 32'h0;
        target_reached = 1'b0;
        prog_wait_flag = 1'b0;
        prog_accu      = 32'hA5A5_0001;
        prog_index     = 32'h0000_5A5A;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        t_user();
        t_pos();
        t_ctrl();
        t_prog();
        t_restart();
        final_report();
    end
endmodule
